// File: design/cst_skip_tests.sv
/*
 * Execution logic for the four conditional skip test instructions:
 * pin level, power-down flag, timer one and timer two request flags.
 * Holds the two timer request flags, the pin polarity and timer enable
 * controls, a skip-pending marker and a small interrupt status block.
 * Assumes the decode path presents one decoded test per instruction
 * cycle on i_instr, the program counter is advanced outside, and the
 * registers are reached by a classic Wishbone master.
 */
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cst_skip_tests
   import cst_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [cst_pkg::CST_ADR_W-1:0] i_wb_adr,
   input wire logic [cst_pkg::CST_DAT_W-1:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [cst_pkg::CST_DAT_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   // decoded instruction, one per instruction cycle
   input wire cst_pkg::cst_instr_s i_instr,
   // flag and pin sources
   input wire logic i_ext_int_pin,
   input wire logic i_powerdown_flag,
   input wire logic i_timer_one_event,
   input wire logic i_timer_two_event,
   // results towards the core
   output cst_pkg::cst_result_s o_result,
   output logic o_skip_pending,
   output logic o_carry_write_en,
   output logic o_timer_one_request_flag,
   output logic o_timer_two_request_flag,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic pin_sync;
   logic [CST_CTL_W-1:0] ext_interrupt_control_reg;
   logic [CST_CTL_W-1:0] timer_int_control_reg;
   logic [CST_ST_W-1:0] irq_status;
   logic [CST_ST_W-1:0] irq_mask;
   logic [CST_ST_W-1:0] next_irq_status;
   logic [CST_ST_W-1:0] status_events;
   logic [CST_ST_W-1:0] status_clear;
   logic pin_polarity_select_bit;
   logic timer_one_int_enable_bit;
   logic timer_two_int_enable_bit;
   logic wb_req;
   logic wb_commit;
   logic wb_write;
   logic wb_read;
   logic [CST_DAT_W-1:0] rd_mux;
   logic instr_take;
   logic instr_kill;
   logic instr_exec;
   cst_outcome_s outcome;
   logic next_t1_flag;
   logic next_t2_flag;

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser

   cst_sync #(
      .WIDTH(1),
      .STAGES(CST_SYNC_STAGES)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async(i_ext_int_pin),
      .o_sync(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // functions

   // evaluates one test against current controls and flags
   function automatic cst_outcome_s test_outcome(
      input cst_op_e op,
      input logic pol,
      input logic pin,
      input logic pd,
      input logic t1f,
      input logic t2f,
      input logic en1,
      input logic en2
   );
      cst_outcome_s r;
      r = '0;
      unique case (op)
         CST_OP_NONE: begin
            r = '0;
         end
         CST_OP_PIN: begin
            // skip when the pin matches the selected level
            r.skip = (pin == pol);
         end
         CST_OP_PD: begin
            r.skip = pd;
         end
         CST_OP_T1: begin
            // enabled interrupt turns the test into a no-operation
            r.skip = !en1 && t1f;
            r.clear_t1 = !en1 && t1f;
         end
         CST_OP_T2: begin
            r.skip = !en2 && t2f;
            r.clear_t2 = !en2 && t2f;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   // writes the low 4 data bits onto a control register when its byte lane is selected
   function automatic logic [CST_CTL_W-1:0] ctl_write(
      input logic [CST_CTL_W-1:0] old,
      input logic [CST_DAT_W-1:0] data,
      input logic lane
   );
      return lane ? data[CST_CTL_W-1:0] : old;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // control bit extraction

   assign pin_polarity_select_bit =
      ext_interrupt_control_reg[CST_POL_BIT];
   assign timer_one_int_enable_bit =
      timer_int_control_reg[CST_T1_EN_BIT];
   assign timer_two_int_enable_bit =
      timer_int_control_reg[CST_T2_EN_BIT];

   ////////////////////////////////////////////////////////////////////
   // instruction execution

   assign instr_take = i_instr.valid;
   // the word after a skip is consumed without running its test
   assign instr_kill = instr_take && o_skip_pending;
   assign instr_exec = instr_take && !o_skip_pending;

   always_comb begin
      if (instr_exec) begin
         outcome = test_outcome(i_instr.op,
                                pin_polarity_select_bit,
                                pin_sync,
                                i_powerdown_flag,
                                o_timer_one_request_flag,
                                o_timer_two_request_flag,
                                timer_one_int_enable_bit,
                                timer_two_int_enable_bit);
      end else begin
         outcome = '0;
      end
   end

   // skip marker: set by a taken skip, consumed by the next word
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_skip_pending <= 1'b0;
      end else if (instr_kill) begin
         o_skip_pending <= 1'b0;
      end else if (outcome.skip) begin
         o_skip_pending <= 1'b1;
      end
   end

   // one-cycle completion report for every word taken
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_result <= '0;
      end else begin
         o_result.done <= instr_take;
         o_result.skip <= outcome.skip;
         o_result.suppressed <= instr_kill;
      end
   end

   // these tests never write the carry
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_carry_write_en <= 1'b0;
      end else begin
         o_carry_write_en <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timer request flags

   // a timer event in the clearing cycle wins, so no request is lost
   always_comb begin
      next_t1_flag = o_timer_one_request_flag;
      if (outcome.clear_t1) begin
         next_t1_flag = 1'b0;
      end
      if (i_timer_one_event) begin
         next_t1_flag = 1'b1;
      end
   end

   always_comb begin
      next_t2_flag = o_timer_two_request_flag;
      if (outcome.clear_t2) begin
         next_t2_flag = 1'b0;
      end
      if (i_timer_two_event) begin
         next_t2_flag = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_timer_one_request_flag <= 1'b0;
         o_timer_two_request_flag <= 1'b0;
      end else begin
         o_timer_one_request_flag <= next_t1_flag;
         o_timer_two_request_flag <= next_t2_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone slave

   assign wb_req = i_wb_cyc && i_wb_stb;
   // writes and read side effects land on the edge that sees ack
   assign wb_commit = wb_req && o_wb_ack;
   assign wb_write = wb_commit && i_wb_we;
   assign wb_read = wb_commit && !i_wb_we;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= wb_req && !o_wb_ack;
      end
   end

   always_comb begin
      rd_mux = CST_DAT_ZERO;
      unique case (i_wb_adr)
         CST_ADR_EXT_CTRL: begin
            rd_mux[CST_CTL_W-1:0] = ext_interrupt_control_reg;
         end
         CST_ADR_TMR_CTRL: begin
            rd_mux[CST_CTL_W-1:0] = timer_int_control_reg;
         end
         CST_ADR_FLAGS: begin
            rd_mux[CST_FL_T1] = o_timer_one_request_flag;
            rd_mux[CST_FL_T2] = o_timer_two_request_flag;
            rd_mux[CST_FL_PIN] = pin_sync;
            rd_mux[CST_FL_PD] = i_powerdown_flag;
            rd_mux[CST_FL_SKIP] = o_skip_pending;
         end
         CST_ADR_IRQ_STATUS: begin
            rd_mux[CST_ST_W-1:0] = irq_status;
         end
         CST_ADR_IRQ_MASK: begin
            rd_mux[CST_ST_W-1:0] = irq_mask;
         end
         default: begin
            rd_mux = CST_DAT_ZERO;
         end
      endcase
   end

   // read data is captured together with ack and held until next one
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_wb_dat <= CST_DAT_ZERO;
      end else if (wb_req && !o_wb_ack) begin
         o_wb_dat <= i_wb_we ? CST_DAT_ZERO : rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ext_interrupt_control_reg <= CST_CTL_RESET;
      end else if (wb_write && i_wb_adr == CST_ADR_EXT_CTRL) begin
         ext_interrupt_control_reg <=
            ctl_write(ext_interrupt_control_reg, i_wb_dat, i_wb_sel[0]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         timer_int_control_reg <= CST_CTL_RESET;
      end else if (wb_write && i_wb_adr == CST_ADR_TMR_CTRL) begin
         timer_int_control_reg <=
            ctl_write(timer_int_control_reg, i_wb_dat, i_wb_sel[0]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_mask <= CST_ST_RESET;
      end else if (wb_write && i_wb_adr == CST_ADR_IRQ_MASK) begin
         irq_mask <= ctl_write(irq_mask, i_wb_dat, i_wb_sel[0]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt status

   always_comb begin
      status_events = CST_ST_RESET;
      status_events[CST_ST_T1_SET] =
         i_timer_one_event && !o_timer_one_request_flag;
      status_events[CST_ST_T2_SET] =
         i_timer_two_event && !o_timer_two_request_flag;
      status_events[CST_ST_SKIP] = outcome.skip;
      status_events[CST_ST_SUPPRESS] = instr_kill;
   end

   // read clears only the bits it returned: a bit set after the data
   // was latched must survive until software has seen it
   assign status_clear = (wb_read && i_wb_adr == CST_ADR_IRQ_STATUS) ?
                         o_wb_dat[CST_ST_W-1:0] : CST_ST_RESET;
   assign next_irq_status = (irq_status & ~status_clear) | status_events;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_status <= CST_ST_RESET;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   // level output, one cycle behind the status it reflects
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status & irq_mask);
      end
   end

endmodule
`default_nettype wire

// File: design/cst_pkg.sv
/*
 * Shared constants and types for the conditional skip test block.
 * Assumes a 50 MHz core clock and a classic Wishbone register master.
 */
// Functional notes
// - pin test polarity from control bit 2
// - polarity 0: skip when pin low
// - polarity 1: skip when pin high
// - power-down test skips on flag, keeps flag
// - timer 1 enable 0: clear flag, skip
// - timer 1 enable 1: test is no-operation
// - timer 1 enable is timer control bit 2
// - timer 2 enable 0: clear flag, skip
// - timer 2 enable 1: test is no-operation
// - timer 2 enable is timer control bit 3
package cst_pkg;

   localparam int unsigned CST_ADR_W = 8;
   localparam int unsigned CST_DAT_W = 32;
   localparam int unsigned CST_CTL_W = 4;
   localparam int unsigned CST_SYNC_STAGES = 2;

   // register byte addresses
   localparam logic [CST_ADR_W-1:0] CST_ADR_EXT_CTRL = 8'h00;
   localparam logic [CST_ADR_W-1:0] CST_ADR_TMR_CTRL = 8'h04;
   localparam logic [CST_ADR_W-1:0] CST_ADR_FLAGS = 8'h08;
   localparam logic [CST_ADR_W-1:0] CST_ADR_IRQ_STATUS = 8'h0C;
   localparam logic [CST_ADR_W-1:0] CST_ADR_IRQ_MASK = 8'h10;

   localparam logic [CST_CTL_W-1:0] CST_CTL_RESET = 4'h0;
   localparam logic [CST_DAT_W-1:0] CST_DAT_ZERO = 32'h0;

   // control field positions
   localparam int unsigned CST_POL_BIT = 2;
   localparam int unsigned CST_T1_EN_BIT = 2;
   localparam int unsigned CST_T2_EN_BIT = 3;

   // flags register layout
   localparam int unsigned CST_FL_T1 = 0;
   localparam int unsigned CST_FL_T2 = 1;
   localparam int unsigned CST_FL_PIN = 2;
   localparam int unsigned CST_FL_PD = 3;
   localparam int unsigned CST_FL_SKIP = 4;
   localparam int unsigned CST_FL_W = 5;

   // interrupt status / mask layout
   localparam int unsigned CST_ST_T1_SET = 0;
   localparam int unsigned CST_ST_T2_SET = 1;
   localparam int unsigned CST_ST_SKIP = 2;
   localparam int unsigned CST_ST_SUPPRESS = 3;
   localparam int unsigned CST_ST_W = 4;
   localparam logic [CST_ST_W-1:0] CST_ST_RESET = 4'h0;

   typedef enum logic [2:0] {
      CST_OP_NONE,
      CST_OP_PIN,
      CST_OP_PD,
      CST_OP_T1,
      CST_OP_T2
   } cst_op_e;

   typedef struct packed {
      logic valid;
      cst_op_e op;
   } cst_instr_s;

   typedef struct packed {
      logic done;
      logic skip;
      logic suppressed;
   } cst_result_s;

   typedef struct packed {
      logic skip;
      logic clear_t1;
      logic clear_t2;
   } cst_outcome_s;

endpackage

// File: design/cst_sync.sv
/*
 * Multi-stage synchroniser for asynchronous level inputs.
 * Assumes inputs are slow levels; no pulse is shorter than a clock.
 */
`timescale 1ns/1ns
`default_nettype none
module cst_sync #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned STAGES = 2
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] chain [STAGES];

   // only the last stage is visible; earlier stages may be metastable
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int i = 0; i < STAGES; i++) begin
            chain[i] <= '0;
         end
      end else begin
         chain[0] <= i_async;
         for (int i = 1; i < STAGES; i++) begin
            chain[i] <= chain[i-1];
         end
      end
   end

   assign o_sync = chain[STAGES-1];

endmodule
`default_nettype wire

// File: verif/cst_skip_tests_sva.sv
/*
 * Port checker for the conditional skip test block.
 * Assumes it is bound to the block and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module cst_skip_tests_sva
   import cst_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire cst_pkg::cst_instr_s i_instr,
   input wire logic i_powerdown_flag,
   input wire logic i_timer_one_event,
   input wire logic i_timer_two_event,
   input wire cst_pkg::cst_result_s o_result,
   input wire logic o_skip_pending,
   input wire logic o_carry_write_en,
   input wire logic o_timer_one_request_flag,
   input wire logic o_timer_two_request_flag
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////
   property p_ack_rise;
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
   endproperty
   a_ack_rise: assert property (p_ack_rise) else $error("ack late");
   property p_ack_pulse;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_done;
      i_instr.valid |=> o_result.done;
   endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_carry;
      !o_carry_write_en;
   endproperty
   a_carry: assert property (p_carry) else $error("carry write");
   property p_kill;
      i_instr.valid && o_skip_pending
      |=> o_result.suppressed && !o_result.skip && !o_skip_pending;
   endproperty
   a_kill: assert property (p_kill) else $error("not killed");
   property p_skip_pend;
      o_result.skip |-> o_skip_pending;
   endproperty
   a_skip_pend: assert property (p_skip_pend) else $error("pend");
   property p_pd;
      i_instr.valid && i_instr.op == CST_OP_PD && !o_skip_pending
      |=> o_result.skip == $past(i_powerdown_flag);
   endproperty
   a_pd: assert property (p_pd) else $error("pd skip wrong");
   property p_t1;
      i_instr.valid && i_instr.op == CST_OP_T1 && !o_skip_pending &&
      o_timer_one_request_flag && !i_timer_one_event
      |=> o_result.skip == !o_timer_one_request_flag;
   endproperty
   a_t1: assert property (p_t1) else $error("t1 skip/clear");
   property p_t2;
      i_instr.valid && i_instr.op == CST_OP_T2 && !o_skip_pending &&
      o_timer_two_request_flag && !i_timer_two_event
      |=> o_result.skip == !o_timer_two_request_flag;
   endproperty
   a_t2: assert property (p_t2) else $error("t2 skip/clear");
endmodule
bind cst_skip_tests cst_skip_tests_sva cst_skip_tests_sva_i (
   .i_clk(i_clk),
   .i_reset(i_reset),
   .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb),
   .o_wb_ack(o_wb_ack),
   .i_instr(i_instr),
   .i_powerdown_flag(i_powerdown_flag),
   .i_timer_one_event(i_timer_one_event),
   .i_timer_two_event(i_timer_two_event),
   .o_result(o_result),
   .o_skip_pending(o_skip_pending),
   .o_carry_write_en(o_carry_write_en),
   .o_timer_one_request_flag(o_timer_one_request_flag),
   .o_timer_two_request_flag(o_timer_two_request_flag)
);
`default_nettype wire

// File: verif/cst_skip_tests_tb_top.sv
/*
 * Self-checking bench for the conditional skip test block.
 * Assumes the package constants and a one-cycle Wishbone answer.
 */
`timescale 1ns/1ns
`default_nettype none
module cst_skip_tests_tb_top;
   import cst_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, o_wb_dat;
   logic [3:0] sel = 4'hF;
   cst_instr_s instr = '0;
   logic pin = 1'b0, pd = 1'b0, e1 = 1'b0, e2 = 1'b0;
   logic o_wb_ack, o_skip_pending, o_carry_write_en, f1, f2, o_irq;
   cst_result_s res;
   int bad_count = 0, n_tests = 0, k;
   logic [19:0] r;
   // ext ctl, tmr ctl, {pin,pd,ev1,ev2}, op, {0,skip,flag1,flag2}
   logic [19:0] rows [13] = '{20'h00014, 20'h00810, 20'h40814, 20'h40010,
      20'h00424, 20'h00020, 20'h00234, 20'h00030, 20'h04232, 20'h08234,
      20'h00346, 20'h08141, 20'h04144};

   always #10 i_clk = ~i_clk;

   cst_skip_tests cst_skip_tests_i (.i_clk(i_clk), .i_reset(i_reset),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_instr(instr), .i_ext_int_pin(pin),
      .i_powerdown_flag(pd), .i_timer_one_event(e1),
      .i_timer_two_event(e2), .o_result(res),
      .o_skip_pending(o_skip_pending), .o_carry_write_en(o_carry_write_en),
      .o_timer_one_request_flag(f1), .o_timer_two_request_flag(f2),
      .o_irq(o_irq));
   ////////////////////////////////////////
   task give_verdict;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
         bad_count++;
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      rdat = o_wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task issue(input cst_op_e op);
      @(posedge i_clk);
      instr <= '{1'b1, op};
      @(posedge i_clk);
      instr <= '0;
      #1;
   endtask
   task pulse(input logic a, input logic b);
      @(posedge i_clk);
      e1 <= a;
      e2 <= b;
      @(posedge i_clk);
      e1 <= 1'b0;
      e2 <= 1'b0;
   endtask
   // both flags end cleared, pending consumed
   task flush;
      wb(1'b1, CST_ADR_TMR_CTRL, 32'h0);
      issue(CST_OP_T1);
      issue(CST_OP_NONE);
      issue(CST_OP_T2);
      issue(CST_OP_NONE);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      chk({o_irq, f1, f2, o_skip_pending, o_wb_ack}, 32'h0);
      wb(1'b0, CST_ADR_EXT_CTRL, 32'h0);
      chk(rdat, 32'h0);
      for (k = 0; k < 13; k++) begin
         r = rows[k];
         @(posedge i_clk);
         pin <= r[11];
         pd <= r[10];
         wb(1'b1, CST_ADR_EXT_CTRL, {28'h0, r[19:16]});
         wb(1'b1, CST_ADR_TMR_CTRL, {28'h0, r[15:12]});
         pulse(r[9], r[8]);
         wb(1'b0, CST_ADR_FLAGS, 32'h0);
         chk(rdat, {28'h0, r[10], r[11], r[8], r[9]});
         issue(cst_op_e'(r[6:4]));
         chk({res.done, o_carry_write_en, res.skip}, {1'b1, 1'b0, r[2]});
         chk({f1, f2}, r[1:0]);
         issue(CST_OP_NONE);
         chk(res.suppressed, r[2]);
         flush();
      end
      // interrupt: raise, clear by read, then masked event
      wb(1'b0, CST_ADR_IRQ_STATUS, 32'h0);
      wb(1'b1, CST_ADR_IRQ_MASK, 32'h4);
      @(posedge i_clk);
      pd <= 1'b1;
      issue(CST_OP_PD);
      repeat (3) @(posedge i_clk);
      #1;
      chk(o_irq, 1'b1);
      wb(1'b0, CST_ADR_IRQ_STATUS, 32'h0);
      chk(rdat, 32'h4);
      issue(CST_OP_NONE);
      repeat (3) @(posedge i_clk);
      #1;
      chk(o_irq, 1'b0);
      wb(1'b0, CST_ADR_IRQ_STATUS, 32'h0);
      chk(rdat, 32'h8);
      pd <= 1'b0;
      // back-to-back: word after a skip leaves flag two alone
      pulse(1'b1, 1'b1);
      instr <= '{1'b1, CST_OP_T1};
      @(posedge i_clk);
      instr <= '{1'b1, CST_OP_T2};
      @(posedge i_clk);
      instr <= '0;
      #1;
      chk({res.suppressed, o_skip_pending, f1, f2}, 32'h9);
      flush();
      wb(1'b1, 8'h40, 32'hF);
      wb(1'b0, 8'h40, 32'h0);
      chk(rdat, 32'h0);
      // lane 0 not selected: write must be ignored
      sel <= 4'h0;
      wb(1'b1, CST_ADR_EXT_CTRL, 32'hF);
      sel <= 4'hF;
      wb(1'b0, CST_ADR_EXT_CTRL, 32'h0);
      chk(rdat, 32'h0);
      // reset in mid-run drops flag one and the interrupt output
      pulse(1'b1, 1'b0);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      chk({f1, o_skip_pending, o_irq}, 32'h0);
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge i_clk);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
